// *** core/fps_pkg.sv ***
package fps_pkg;
	localparam int NUM_STG = 8;
	localparam int NUM_OF  = 4;
	localparam int NUM_UF  = 4;
	localparam int FW      = 16;
	localparam int DW      = 19;
	localparam int MW      = 3;
	localparam int EW      = 24;

	localparam logic [7:0] CTRL_OFS  = 8'h00;
	localparam logic [7:0] MODE_OFS  = 8'h04;
	localparam logic [7:0] ENA_OFS   = 8'h08;
	localparam logic [7:0] FORCE_OFS = 8'h0c;
	localparam logic [7:0] THR_OFS   = 8'h10;
	localparam logic [7:0] UV_OFS    = 8'h30;
	localparam logic [7:0] DLY_OFS   = 8'h40;
	localparam logic [7:0] STAT_OFS  = 8'h60;
	localparam logic [7:0] ISTAT_OFS = 8'h64;
	localparam logic [7:0] IMASK_OFS = 8'h68;
	localparam logic [7:0] FREQ_OFS  = 8'h6c;

	localparam int CTRL_ACT_BIT   = 0;
	localparam int CTRL_ALLOW_BIT = 1;
	localparam int CTRL_FORCE_BIT = 2;
	localparam int CTRL_REF_LSB   = 3;
	localparam int CTRL_W         = 5;
	localparam int EV_START_LSB   = 0;
	localparam int EV_TRIP_LSB    = 8;
	localparam int EV_BLK_LSB     = 16;

	localparam logic [MW-1:0] MODE_ON      = 3'h0;
	localparam logic [MW-1:0] MODE_BLOCKED = 3'h1;
	localparam logic [MW-1:0] MODE_TEST    = 3'h2;
	localparam logic [MW-1:0] MODE_TESTBLK = 3'h3;
	localparam logic [MW-1:0] MODE_OFF     = 3'h4;

	localparam logic [1:0] FORCE_NORMAL  = 2'h0;
	localparam logic [1:0] FORCE_START   = 2'h1;
	localparam logic [1:0] FORCE_TRIP    = 2'h2;
	localparam logic [1:0] FORCE_BLOCKED = 2'h3;

	localparam logic [1:0] REF_PRIMARY   = 2'h0;
	localparam logic [1:0] REF_SECONDARY = 2'h1;
	localparam logic [1:0] REF_TERTIARY  = 2'h2;

	localparam logic [FW-1:0] THR_OF_RST = 16'h13ec;
	localparam logic [FW-1:0] THR_UF_RST = 16'h1324;
	localparam logic [FW-1:0] UV_RST     = 16'h0000;
	localparam logic [DW-1:0] DLY_RST    = 19'h00008;
	localparam logic [7:0]    ENA_RST    = 8'h00;

	localparam int FREQ_LSB_MHZ = 10;
	localparam int HYST_MHZ     = 20;
	localparam logic [FW:0] HYST_LSB = 17'(HYST_MHZ / FREQ_LSB_MHZ);

	localparam int REF_PERIOD_US = 5000;
	localparam int CLK_MHZ       = 100;
	localparam int TICK_CYCLES   = REF_PERIOD_US * CLK_MHZ;

	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_TRIP, ST_BLOCKED} fps_state_type;
endpackage : fps_pkg

// *** core/fps_stage_if.sv ***
`timescale 1ns/1ps
interface fps_stage_if;
	logic [15:0] thr;
	logic [18:0] dly;
	logic [15:0] uv;
	logic        en;
	logic        start;
	logic        trip;
	logic        blocked;
	modport ctl (output thr, dly, uv, en, input start, trip, blocked);
	modport stg (input thr, dly, uv, en, output start, trip, blocked);
endinterface : fps_stage_if

// *** core/fps_stage.sv ***
`timescale 1ns/1ps
module fps_stage #(
	parameter bit OVER = 1'b1
) (
	input  wire logic        pclk,    // Processing clock.
	input  wire logic        presetn, // Asynchronous reset, active low.
	input  wire logic        ce,      // Clock enable.
	input  wire logic        tick,    // One pulse per evaluation period.
	input  wire logic [15:0] freq,    // Measured frequency, 0.01 Hz units.
	input  wire logic [15:0] volt,    // Measured voltage, 0.01 %Un units.
	input  wire logic        block,   // Effective blocking input.
	fps_stage_if.stg         s        // Settings in, status out.
);
	fps_pkg::fps_state_type state_reg;
	logic                   picked_reg;
	logic [18:0]            cnt_reg;
	logic                   set_c;
	logic                   hold_c;
	logic                   uv_inh;
	logic                   pick_next;

	always_comb begin
		if (OVER) begin
			set_c  = freq > s.thr;
			hold_c = ({1'b0, freq} + fps_pkg::HYST_LSB) > {1'b0, s.thr};
		end else begin
			set_c  = freq < s.thr;
			hold_c = {1'b0, freq} < ({1'b0, s.thr} + fps_pkg::HYST_LSB);
		end
		uv_inh    = !OVER && (s.uv != 16'h0000) && (volt < s.uv);
		pick_next = s.en && !uv_inh && (picked_reg ? hold_c : set_c);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			picked_reg <= 1'b0;
		end else if (ce && tick) begin
			picked_reg <= pick_next;
		end
	end

	// Definite time only: trip follows start after dly periods.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= fps_pkg::ST_IDLE;
			cnt_reg   <= 19'h00000;
		end else if (ce && tick) begin
			if (!pick_next) begin
				state_reg <= fps_pkg::ST_IDLE;
				cnt_reg   <= 19'h00000;
			end else if (block) begin
				state_reg <= fps_pkg::ST_BLOCKED;
				cnt_reg   <= 19'h00000;
			end else begin
				case (state_reg)
					fps_pkg::ST_IDLE, fps_pkg::ST_BLOCKED: begin
						cnt_reg   <= 19'h00000;
						state_reg <= (s.dly == 19'h00000) ? fps_pkg::ST_TRIP
						                                  : fps_pkg::ST_START;
					end
					fps_pkg::ST_START: begin
						if (cnt_reg + 19'h00001 >= s.dly) begin
							state_reg <= fps_pkg::ST_TRIP;
						end else begin
							cnt_reg <= cnt_reg + 19'h00001;
						end
					end
					fps_pkg::ST_TRIP: begin
						state_reg <= fps_pkg::ST_TRIP;
					end
					default: begin
						state_reg <= fps_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	assign s.start   = (state_reg == fps_pkg::ST_START) || (state_reg == fps_pkg::ST_TRIP);
	assign s.trip    = state_reg == fps_pkg::ST_TRIP;
	assign s.blocked = state_reg == fps_pkg::ST_BLOCKED;
endmodule : fps_stage

// *** core/fps_freq_protection_block.sv ***
// What this block does
// - Four overfrequency and four underfrequency stages, each with own threshold and status.
// - Each stage switches on or off at will once the function is active.
// - Per-stage enable, No or Yes, reset to No so the stage is inactive.
// - Pick-up compares measured frequency in 0.01 Hz units against the stage threshold.
// - Three references, primary, secondary, tertiary, evaluated every 5 ms.
// - Node mode On, Blocked, Test, Test/Blocked, Off; reset On; writable when allowed.
// - Forced status Normal, Start, Trip, Blocked; acts only while forcing is enabled.
// - Mode, enable and forcing settings are static; no group switch alters them.
// - Pick-up releases with a fixed 20 mHz hysteresis around the threshold.
// - Underfrequency stage inhibited below its voltage block level; zero disables this.
// - Blocking at pick-up gives blocked instead of start; an active start resets.
// - Only a definite-time delay lies between start and trip.
`timescale 1ns/1ps
module fps_freq_protection_block #(
	parameter int TICK_CYCLES = fps_pkg::TICK_CYCLES
) (
	input  wire logic        pclk,          // APB and processing clock.
	input  wire logic        presetn,       // Asynchronous reset, active low.
	input  wire logic        ce,            // Clock enable, freezes all state when low.
	input  wire logic        psel,          // APB select.
	input  wire logic        penable,       // APB enable.
	input  wire logic        pwrite,        // APB direction.
	input  wire logic [7:0]  paddr,         // APB byte address.
	input  wire logic [31:0] pwdata,        // APB write data.
	output logic      [31:0] prdata,        // APB read data.
	output logic             pready,        // APB ready.
	output logic             pslverr,       // APB error on unmapped address.
	input  wire logic [15:0] freq_ref1,     // Primary reference, 0.01 Hz units.
	input  wire logic [15:0] freq_ref2,     // Secondary reference.
	input  wire logic [15:0] freq_ref3,     // Tertiary reference.
	input  wire logic [15:0] volt_meas,     // Measured voltage, 0.01 %Un units.
	input  wire logic        block_in,      // Blocking input from the blocking matrix.
	output logic      [7:0]  stage_start,   // Start per stage, 3:0 over, 7:4 under.
	output logic      [7:0]  stage_trip,    // Trip per stage.
	output logic      [7:0]  stage_blocked, // Blocked per stage.
	output logic             test_mode,     // Node is in a test mode.
	output logic             irq            // Level interrupt.
);
	localparam int NS = fps_pkg::NUM_STG;

	logic [fps_pkg::CTRL_W-1:0] ctrl_reg;
	logic [fps_pkg::MW-1:0]     mode_reg;
	logic [NS-1:0]              ena_reg;
	logic [2*NS-1:0]            force_reg;
	logic [15:0]                thr_reg [NS];
	logic [15:0]                uv_reg [fps_pkg::NUM_UF];
	logic [18:0]                dly_reg [NS];
	logic [fps_pkg::EW-1:0]     istat_reg;
	logic [fps_pkg::EW-1:0]     istat_next;
	logic [fps_pkg::EW-1:0]     imask_reg;
	logic [31:0]                prdata_reg;
	logic [31:0]                tick_cnt_reg;
	logic [15:0]                freq_reg;
	logic [7:0]                 start_reg;
	logic [7:0]                 trip_reg;
	logic [7:0]                 blk_reg;
	logic [7:0]                 start_next;
	logic [7:0]                 trip_next;
	logic [7:0]                 blk_next;
	logic [7:0]                 st_start;
	logic [7:0]                 st_trip;
	logic [7:0]                 st_blk;
	logic [fps_pkg::EW-1:0]     rise;
	logic [31:0]                rdata;
	logic                       hit;
	logic                       tick;
	logic                       wr_en;
	logic                       func_on;
	logic                       block_eff;
	logic [15:0]                freq_sel;
	logic [1:0]                 ref_sel;

	assign wr_en   = psel && penable && pwrite && ce;
	assign ref_sel = ctrl_reg[fps_pkg::CTRL_REF_LSB +: 2];
	assign tick    = tick_cnt_reg == 32'(TICK_CYCLES - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_reg <= 32'h00000000;
		end else if (ce) begin
			tick_cnt_reg <= tick ? 32'h00000000 : tick_cnt_reg + 32'h00000001;
		end
	end

	always_comb begin
		case (ref_sel)
			fps_pkg::REF_SECONDARY: freq_sel = freq_ref2;
			fps_pkg::REF_TERTIARY:  freq_sel = freq_ref3;
			default:                freq_sel = freq_ref1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_reg <= 16'h0000;
		end else if (ce && tick) begin
			freq_reg <= freq_sel;
		end
	end

	// Off silences every stage; the two blocked modes act as a held block.
	assign func_on   = ctrl_reg[fps_pkg::CTRL_ACT_BIT] && (mode_reg != fps_pkg::MODE_OFF);
	assign block_eff = block_in || (mode_reg == fps_pkg::MODE_BLOCKED)
	                            || (mode_reg == fps_pkg::MODE_TESTBLK);

	fps_stage_if sif [NS] ();

	genvar g;
	generate
		for (g = 0; g < NS; g++) begin : g_stage
			assign sif[g].thr = thr_reg[g];
			assign sif[g].dly = dly_reg[g];
			assign sif[g].en  = func_on && ena_reg[g];
			if (g < fps_pkg::NUM_OF) begin : g_over
				assign sif[g].uv = 16'h0000;
			end else begin : g_under
				assign sif[g].uv = uv_reg[g - fps_pkg::NUM_OF];
			end
			fps_stage #(
				.OVER (g < fps_pkg::NUM_OF)
			) u_stage (
				.pclk    (pclk),
				.presetn (presetn),
				.ce      (ce),
				.tick    (tick),
				.freq    (freq_sel),
				.volt    (volt_meas),
				.block   (block_eff),
				.s       (sif[g])
			);
			assign st_start[g] = sif[g].start;
			assign st_trip[g]  = sif[g].trip;
			assign st_blk[g]   = sif[g].blocked;
		end
	endgenerate

	// Forcing overrides the reported status only while globally enabled.
	always_comb begin
		for (int i = 0; i < NS; i++) begin
			start_next[i] = st_start[i];
			trip_next[i]  = st_trip[i];
			blk_next[i]   = st_blk[i];
			if (ctrl_reg[fps_pkg::CTRL_FORCE_BIT]) begin
				case (force_reg[2*i +: 2])
					fps_pkg::FORCE_START: begin
						start_next[i] = 1'b1;
						trip_next[i]  = 1'b0;
						blk_next[i]   = 1'b0;
					end
					fps_pkg::FORCE_TRIP: begin
						start_next[i] = 1'b1;
						trip_next[i]  = 1'b1;
						blk_next[i]   = 1'b0;
					end
					fps_pkg::FORCE_BLOCKED: begin
						start_next[i] = 1'b0;
						trip_next[i]  = 1'b0;
						blk_next[i]   = 1'b1;
					end
					default: begin
						start_next[i] = st_start[i];
						trip_next[i]  = st_trip[i];
						blk_next[i]   = st_blk[i];
					end
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_reg <= 8'h00;
			trip_reg  <= 8'h00;
			blk_reg   <= 8'h00;
		end else if (ce) begin
			start_reg <= start_next;
			trip_reg  <= trip_next;
			blk_reg   <= blk_next;
		end
	end

	assign stage_start   = start_reg;
	assign stage_trip    = trip_reg;
	assign stage_blocked = blk_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			test_mode <= 1'b0;
		end else if (ce) begin
			test_mode <= (mode_reg == fps_pkg::MODE_TEST) || (mode_reg == fps_pkg::MODE_TESTBLK);
		end
	end

	// Events are rising edges of the reported status; a new event beats a clear.
	assign rise = {blk_next & ~blk_reg, trip_next & ~trip_reg, start_next & ~start_reg};

	always_comb begin
		istat_next = istat_reg;
		if (wr_en && paddr == fps_pkg::ISTAT_OFS) begin
			istat_next = istat_next & ~pwdata[fps_pkg::EW-1:0];
		end
		istat_next = istat_next | rise;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat_reg <= 24'h000000;
		end else if (ce) begin
			istat_reg <= istat_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(istat_next & imask_reg);
		end
	end

	// Static settings: only software writes change them.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= '0;
		end else if (wr_en && paddr == fps_pkg::CTRL_OFS) begin
			ctrl_reg <= pwdata[fps_pkg::CTRL_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= fps_pkg::MODE_ON;
		end else if (wr_en && paddr == fps_pkg::MODE_OFS) begin
			if (ctrl_reg[fps_pkg::CTRL_ALLOW_BIT] && pwdata[2:0] <= fps_pkg::MODE_OFF) begin
				mode_reg <= pwdata[2:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ena_reg <= fps_pkg::ENA_RST;
		end else if (wr_en && paddr == fps_pkg::ENA_OFS) begin
			ena_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			force_reg <= 16'h0000;
		end else if (wr_en && paddr == fps_pkg::FORCE_OFS) begin
			force_reg <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			imask_reg <= 24'h000000;
		end else if (wr_en && paddr == fps_pkg::IMASK_OFS) begin
			imask_reg <= pwdata[fps_pkg::EW-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NS; i++) begin
				thr_reg[i] <= (i < fps_pkg::NUM_OF) ? fps_pkg::THR_OF_RST : fps_pkg::THR_UF_RST;
				dly_reg[i] <= fps_pkg::DLY_RST;
			end
		end else if (wr_en) begin
			for (int i = 0; i < NS; i++) begin
				if (paddr == fps_pkg::THR_OFS + 8'(4 * i)) begin
					thr_reg[i] <= pwdata[15:0];
				end
				if (paddr == fps_pkg::DLY_OFS + 8'(4 * i)) begin
					dly_reg[i] <= pwdata[18:0];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < fps_pkg::NUM_UF; i++) begin
				uv_reg[i] <= fps_pkg::UV_RST;
			end
		end else if (wr_en) begin
			for (int i = 0; i < fps_pkg::NUM_UF; i++) begin
				if (paddr == fps_pkg::UV_OFS + 8'(4 * i)) begin
					uv_reg[i] <= pwdata[15:0];
				end
			end
		end
	end

	always_comb begin
		rdata = 32'h00000000;
		hit   = 1'b1;
		case (paddr)
			fps_pkg::CTRL_OFS:  rdata = 32'(ctrl_reg);
			fps_pkg::MODE_OFS:  rdata = 32'(mode_reg);
			fps_pkg::ENA_OFS:   rdata = 32'(ena_reg);
			fps_pkg::FORCE_OFS: rdata = 32'(force_reg);
			fps_pkg::STAT_OFS:  rdata = {8'h00, blk_reg, trip_reg, start_reg};
			fps_pkg::ISTAT_OFS: rdata = 32'(istat_reg);
			fps_pkg::IMASK_OFS: rdata = 32'(imask_reg);
			fps_pkg::FREQ_OFS:  rdata = 32'(freq_reg);
			default: begin
				hit = 1'b0;
				for (int i = 0; i < NS; i++) begin
					if (paddr == fps_pkg::THR_OFS + 8'(4 * i)) begin
						rdata = 32'(thr_reg[i]);
						hit   = 1'b1;
					end
					if (paddr == fps_pkg::DLY_OFS + 8'(4 * i)) begin
						rdata = 32'(dly_reg[i]);
						hit   = 1'b1;
					end
				end
				for (int i = 0; i < fps_pkg::NUM_UF; i++) begin
					if (paddr == fps_pkg::UV_OFS + 8'(4 * i)) begin
						rdata = 32'(uv_reg[i]);
						hit   = 1'b1;
					end
				end
			end
		endcase
	end

	// Read data is captured in the setup cycle so it comes from a flip-flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h00000000;
		end else if (ce && psel && !penable) begin
			prdata_reg <= pwrite ? 32'h00000000 : rdata;
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = ce;
	assign pslverr = psel && penable && ce && !hit;
endmodule : fps_freq_protection_block

// *** tb/fps_chk_props.sv ***
`timescale 1ns/1ps
module fps_chk #(
	parameter int TICK_CYCLES = 10
) (
	input wire logic        pclk,          // Clock.
	input wire logic        presetn,       // Reset, active low.
	input wire logic        ce,            // Clock enable.
	input wire logic        psel,          // APB select.
	input wire logic        penable,       // APB enable.
	input wire logic        pwrite,        // APB direction.
	input wire logic [7:0]  paddr,         // APB address.
	input wire logic [31:0] pwdata,        // APB write data.
	input wire logic [31:0] prdata,        // APB read data.
	input wire logic        pready,        // APB ready.
	input wire logic        pslverr,       // APB error.
	input wire logic [15:0] freq_ref1,     // Primary reference.
	input wire logic [15:0] freq_ref2,     // Secondary reference.
	input wire logic [15:0] freq_ref3,     // Tertiary reference.
	input wire logic [15:0] volt_meas,     // Voltage.
	input wire logic        block_in,      // Blocking input.
	input wire logic [7:0]  stage_start,   // Start per stage.
	input wire logic [7:0]  stage_trip,    // Trip per stage.
	input wire logic [7:0]  stage_blocked, // Blocked per stage.
	input wire logic        test_mode,     // Test mode.
	input wire logic        irq            // Interrupt.
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_access;
		psel && penable;
	endsequence
	sequence s_start_rise;
		(stage_start & ~$past(stage_start)) != 8'h00;
	endsequence
	AST_PREADY: assert property (pready == ce) else $error("pready differs from ce");
	AST_SLVERR: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
	AST_WR_ZERO: assert property (s_access ##0 pwrite |-> prdata == 32'h0)
		else $error("write shows read data");
	AST_UNMAP_ZERO: assert property (s_access ##0 pslverr |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	AST_RST_QUIET: assert property ($rose(presetn) |-> (stage_start == 8'h00 && !irq)[*2])
		else $error("outputs active after reset");
	AST_TRIP_START: assert property ((stage_trip & ~stage_start) == 8'h00)
		else $error("trip without start");
	AST_BLK_START: assert property ((stage_blocked & stage_start) == 8'h00)
		else $error("blocked and start together");
	AST_START_UNBLK: assert property (s_start_rise |-> !$past(block_in, 2))
		else $error("start while blocking input set");
	AST_FREEZE: assert property (!ce |=> $stable({stage_start, stage_trip, stage_blocked}))
		else $error("status moved with ce low");
endmodule : fps_chk
bind fps_freq_protection_block fps_chk #(.TICK_CYCLES(TICK_CYCLES)) u_fps_chk (
	.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .freq_ref1(freq_ref1), .freq_ref2(freq_ref2),
	.freq_ref3(freq_ref3), .volt_meas(volt_meas), .block_in(block_in),
	.stage_start(stage_start), .stage_trip(stage_trip),
	.stage_blocked(stage_blocked), .test_mode(test_mode), .irq(irq));

// *** tb/fps_meas_model.sv ***
`timescale 1ns/1ps
module fps_meas_model #(
	parameter logic [15:0] OFS2 = 16'h0064,
	parameter logic [15:0] OFS3 = 16'h00c8
) (
	input  wire logic        pclk,      // Clock.
	input  wire logic        presetn,   // Reset, active low.
	input  wire logic [15:0] f_set,     // Frequency to report.
	input  wire logic [15:0] v_set,     // Voltage to report.
	input  wire logic        blk_set,   // Blocking request.
	output logic      [15:0] freq_ref1, // Primary reference.
	output logic      [15:0] freq_ref2, // Secondary reference.
	output logic      [15:0] freq_ref3, // Tertiary reference.
	output logic      [15:0] volt_meas, // Voltage.
	output logic             block_in   // Blocking matrix output.
);
	// The three trackers see one system; primary has no offset, secondary and tertiary each add a fixed offset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_ref1 <= 16'h0000;
			freq_ref2 <= 16'h0000;
			freq_ref3 <= 16'h0000;
			volt_meas <= 16'h0000;
			block_in  <= 1'b0;
		end else begin
			freq_ref1 <= f_set;
			freq_ref2 <= f_set + OFS2;
			freq_ref3 <= f_set + OFS3;
			volt_meas <= v_set;
			block_in  <= blk_set;
		end
	end
endmodule : fps_meas_model

// *** tb/tb_frequency_protection_stages.sv ***
`timescale 1ns/1ps
module tb_frequency_protection_stages;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic        irq, test_mode, blk, bi, se;
	logic [7:0]  paddr, stage_start, stage_trip, stage_blocked;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] f_set, v_set, r1, r2, r3, vm, fr;
	int          err_count, checked, cyc_n, seed, k;

	fps_meas_model u_fps_meas_model (.pclk(pclk), .presetn(presetn), .f_set(f_set),
		.v_set(v_set), .blk_set(blk), .freq_ref1(r1), .freq_ref2(r2), .freq_ref3(r3),
		.volt_meas(vm), .block_in(bi));
	fps_freq_protection_block #(.TICK_CYCLES(10)) u_fps_freq_protection_block (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .freq_ref1(r1), .freq_ref2(r2),
		.freq_ref3(r3), .volt_meas(vm), .block_in(bi), .stage_start(stage_start),
		.stage_trip(stage_trip), .stage_blocked(stage_blocked),
		.test_mode(test_mode), .irq(irq));

	initial pclk = 1'b0;
	always #5 pclk = ~pclk;

	task results;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results

	always @(posedge pclk) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 20000) begin
			err_count++;
			results();
		end
	end

	task chk(input logic [31:0] g, input logic [31:0] e, input string s);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("Error %0t: %s got %h exp %h", $time, s, g, e);
		end
	endtask : chk

	task wt(input int n);
		repeat (n) @(posedge pclk);
	endtask : wt

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task rdc(input logic [7:0] a, input logic [31:0] e, input string s);
		apb(1'b0, a, 32'h0);
		chk(rd, e, s);
	endtask : rdc

	task st(input logic [7:0] e, input string s);
		chk(32'(stage_start), 32'(e), s);
	endtask : st

	function automatic logic [7:0] exp_start(input logic [15:0] x);
		exp_start = {x < fps_pkg::THR_UF_RST ? 4'hf : 4'h0, x > fps_pkg::THR_OF_RST ? 4'hf : 4'h0};
	endfunction : exp_start

	function automatic logic [2:0] exp_force(input logic [1:0] c);
		exp_force = (c == 2'h3) ? 3'b100 : {1'b0, c[1], c != 2'h0};
	endfunction : exp_force

	initial begin
		seed = 45;
		{psel, penable, pwrite, blk} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ce = 1'b1;
		presetn = 1'b0;
		f_set = 16'd5000;
		v_set = 16'd10000;
		wt(20);
		presetn <= 1'b1;
		wt(1);
		rdc(8'h08, 32'h0, "enable");
		rdc(8'h04, 32'h0, "mode");
		rdc(8'h10, 32'(fps_pkg::THR_OF_RST), "thr over");
		rdc(8'h20, 32'(fps_pkg::THR_UF_RST), "thr under");
		apb(1'b0, 8'h70, 32'h0);
		chk({31'h0, se}, 32'h1, "slverr");
		$display("test reset done");
		apb(1'b1, 8'h08, 32'hff);
		for (k = 0; k < 8; k++) apb(1'b1, 8'h40 + 8'(4 * k), 32'h2);
		f_set <= 16'd5200;
		wt(25);
		st(8'h00, "inactive");
		apb(1'b1, 8'h00, 32'h1);
		wt(12);
		st(8'h0f, "over pickup");
		chk(32'(stage_trip), 32'h0, "early trip");
		wt(25);
		chk(32'(stage_trip), 32'h0f, "delayed trip");
		f_set <= 16'd5099;
		wt(25);
		st(8'h0f, "hyst hold");
		f_set <= 16'd5098;
		wt(25);
		st(8'h00, "hyst release");
		$display("test pickup done");
		blk <= 1'b1;
		f_set <= 16'd5200;
		wt(25);
		chk(32'(stage_blocked), 32'h0f, "blocked");
		blk <= 1'b0;
		wt(25);
		st(8'h0f, "unblocked");
		blk <= 1'b1;
		wt(25);
		st(8'h00, "start reset");
		blk <= 1'b0;
		f_set <= 16'd5000;
		wt(25);
		apb(1'b1, 8'h30, 32'd100);
		v_set <= 16'd50;
		f_set <= 16'd4850;
		wt(25);
		st(8'he0, "uv inhibit");
		v_set <= 16'd200;
		wt(25);
		st(8'hf0, "under pickup");
		apb(1'b1, 8'h08, 32'h7f);
		wt(25);
		st(8'h70, "stage off");
		apb(1'b1, 8'h08, 32'hff);
		f_set <= 16'd5000;
		wt(25);
		$display("test block done");
		for (k = 0; k < 3; k++) begin
			apb(1'b1, 8'h00, 32'(1 + 8 * k));
			wt(25);
			rdc(8'h6c, 32'(5000 + 100 * k), "ref");
			st(k == 2 ? 8'h0f : 8'h00, "ref pickup");
		end
		f_set <= 16'd5200;
		apb(1'b1, 8'h04, 32'h4);
		rdc(8'h04, 32'h0, "mode locked");
		apb(1'b1, 8'h00, 32'h3);
		for (k = 0; k < 5; k++) begin
			apb(1'b1, 8'h04, 32'(k));
			rdc(8'h04, 32'(k), "mode");
			chk(32'(test_mode), 32'(k == 2 || k == 3), "test mode");
			wt(25);
			st((k == 0 || k == 2) ? 8'h0f : 8'h00, "mode start");
			chk(32'(stage_blocked), (k == 1 || k == 3) ? 32'h0f : 32'h0, "mode blk");
		end
		apb(1'b1, 8'h04, 32'h5);
		rdc(8'h04, 32'h4, "bad mode");
		apb(1'b1, 8'h04, 32'h0);
		f_set <= 16'd5000;
		wt(25);
		$display("test mode done");
		apb(1'b1, 8'h0c, 32'h1);
		wt(2);
		st(8'h00, "force off");
		apb(1'b1, 8'h00, 32'h7);
		for (k = 0; k < 4; k++) begin
			apb(1'b1, 8'h0c, 32'(k));
			wt(1);
			chk(32'({stage_blocked[0], stage_trip[0], stage_start[0]}), 32'(exp_force(2'(k))),
				"force");
		end
		apb(1'b1, 8'h0c, 32'h0);
		apb(1'b1, 8'h00, 32'h1);
		wt(25);
		$display("test force done");
		apb(1'b1, 8'h64, 32'hffffff);
		apb(1'b1, 8'h68, 32'h1);
		f_set <= 16'd5200;
		wt(25);
		chk(32'(irq), 32'h1, "irq set");
		apb(1'b1, 8'h68, 32'h0);
		wt(2);
		chk(32'(irq), 32'h0, "irq masked");
		f_set <= 16'd5000;
		wt(25);
		apb(1'b1, 8'h64, 32'hffffff);
		apb(1'b1, 8'h68, 32'h1);
		wt(2);
		chk(32'(irq), 32'h0, "irq cleared");
		rdc(8'h64, 32'h0, "istat");
		apb(1'b1, 8'h68, 32'h0);
		$display("test irq done");
		for (k = 0; k < 6; k++) begin
			fr = 16'(4800 + ($unsigned($random(seed)) % 400));
			f_set <= fr;
			wt(25);
			st(exp_start(fr), "random");
			f_set <= 16'd5000;
			wt(25);
		end
		ce <= 1'b0;
		wt(2);
		chk(32'(pready), 32'h0, "pready ce");
		ce <= 1'b1;
		wt(1);
		$display("test random done");
		results();
	end
endmodule : tb_frequency_protection_stages
